// >>> hw/pfms_pkg.sv
// Package of the PWM fault mask and status block: register indices, bit positions,
// reset values, source carrier struct and recovery states.
// Assumes a 32-bit classic Wishbone bus with one register per aligned word.
`default_nettype none
package pfms_pkg;

   // Register indices; the byte address is four times the index
   localparam logic [29:0] FSM_IDX        = 30'h00FFE384;     // fault_source_mask
   localparam logic [29:0] FEF_IDX        = 30'h00FFE385;     // fault_event_flags

   // fault_source_mask field positions
   localparam int          MSK_F0_BIT     = 0;                // first_pin_mask
   localparam int          MSK_CMP_BIT    = 1;                // comparator_mask
   localparam int          MSK_F1_BIT     = 2;                // second_input_mask
   localparam int          MSK_DBG_BIT    = 5;                // debug_entry_mask
   localparam logic [7:0]  MSK_RW_BITS    = 8'h27;            // Bits that can be written
   localparam logic [7:0]  MSK_RESET      = 8'h00;            // Every source enabled

   // fault_event_flags field positions
   localparam int          FLG_F0_BIT     = 0;                // first_pin_flag
   localparam int          FLG_F1_BIT     = 1;                // second_input_flag
   localparam int          FLG_CMP_BIT    = 2;                // comparator_event_flag
   localparam int          FLG_DBG_BIT    = 5;                // debug_entry_flag
   localparam int          FLG_RLD_BIT    = 7;                // reload_seen_flag
   localparam logic        FLG_RESET      = 1'b0;             // Reset value of every flag cell

   // Source index inside the flag vector
   localparam int          SRC_F0         = 0;
   localparam int          SRC_F1         = 1;
   localparam int          SRC_CMP        = 2;
   localparam int          SRC_DBG        = 3;
   localparam int          SRC_N          = 4;

   // Number of synchroniser stages for outside inputs
   localparam int          SYNC_STAGES    = 2;

   // One bit per fault source
   typedef struct packed {
      logic dbg;                                              // CPU in debug mode
      logic cmp;                                              // Comparator 0 output
      logic f1;                                               // Fault-1 input
      logic f0;                                               // Fault-0 pin
   } pfms_src_t;

   // Output stage ownership
   typedef enum logic [0:0] {
      PFMS_RUN  = 1'b0,                                       // PWM drives the outputs
      PFMS_HOLD = 1'b1                                        // Outputs forced off
   } pfms_state_t;

endpackage : pfms_pkg
`default_nettype wire

// >>> hw/pfms_sync.sv
// Two-stage synchroniser, one per bit of a bus of independent levels.
// Assumes each bit is a slow level; words are not kept coherent.
`timescale 1ns/10ps
`default_nettype none
module pfms_sync
   import pfms_pkg::*;
#(
   parameter int W = 1                                        // Number of levels
) (
   input  wire logic         sys_clk_i,                       // System clock
   input  wire logic         rstn_i,                          // Async reset, active low
   input  wire logic [W-1:0] async_i,                         // Levels from outside
   output logic      [W-1:0] sync_o                           // Levels in clock domain
);

   logic [W-1:0] meta_ff;                                     // First stage, read only by second
   logic [W-1:0] sync_ff;                                     // Second stage
   logic [W-1:0] nxt_meta;
   logic [W-1:0] nxt_sync;

   // Next values: plain shift
   always_comb begin
      nxt_meta = async_i;
      nxt_sync = meta_ff;
   end

   // Registers
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign sync_o = sync_ff;

endmodule : pfms_sync
`default_nettype wire

// >>> hw/pfms_flag.sv
// Sticky event flag with write-one-to-clear; a set in the clear cycle wins.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module pfms_flag
   import pfms_pkg::*;
(
   input  wire logic sys_clk_i,                               // System clock
   input  wire logic rstn_i,                                  // Async reset, active low
   input  wire logic set_i,                                   // Event, sets the flag
   input  wire logic clr_i,                                   // Qualified clear request
   output logic      flag_o                                   // Flag value
);

   logic flag_ff;                                             // Stored flag
   logic nxt_flag;

   // Set wins over clear so no event is lost
   always_comb begin
      nxt_flag = flag_ff;
      if (set_i) begin
         nxt_flag = 1'b1;
      end else if (clr_i) begin
         nxt_flag = 1'b0;
      end
   end

   // Register
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flag_ff <= FLG_RESET;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   assign flag_o = flag_ff;

endmodule : pfms_flag
`default_nettype wire

// >>> hw/pfms_top.sv
// Top of the PWM fault mask and status block: Wishbone slave for the two
// registers, fault source masking, sticky flags and output hold control.
// Assumes the timer gives a one-cycle reload pulse on this clock, the
// debug-mode level comes from the CPU on this clock, and the fault pins
// and comparator are asynchronous levels, active high.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module pfms_top
   import pfms_pkg::*;
(
   input  wire logic        sys_clk_i,                        // System clock, 125 MHz
   input  wire logic        rstn_i,                           // Async reset, active low
   // Classic Wishbone slave
   input  wire logic        wb_cyc_i,                         // Cycle
   input  wire logic        wb_stb_i,                         // Strobe
   input  wire logic        wb_we_i,                          // Write enable
   input  wire logic [31:0] wb_adr_i,                         // Byte address
   input  wire logic [3:0]  wb_sel_i,                         // Byte lanes
   input  wire logic [31:0] wb_dat_i,                         // Write data
   output logic      [31:0] wb_dat_o,                         // Read data
   output logic             wb_ack_o,                         // Acknowledge
   // Fault sources
   input  wire logic        fault0_pin_i,                     // Fault-0 pin, async
   input  wire logic        fault1_i,                         // Fault-1 input, async
   input  wire logic        cmp0_i,                           // Comparator 0, async
   input  wire logic        debug_mode_i,                     // CPU in debug mode, same clock
   // Timer and recovery
   input  wire logic        reload_i,                         // Timer reload pulse
   input  wire logic        sw_recovery_i,                    // 1: software-controlled recovery
   // Results
   output logic             pwm_fault_o,                      // An enabled source is active
   output logic             sys_fault_exc_o,                  // Comparator system fault
   output logic             outputs_off_o                     // Force PWM outputs off
);

   ////////////////////////////////////////////////////////////////////////////
   // Source synchronisation

   logic [2:0] async_src;                                     // Outside levels
   logic [2:0] sync_src;                                      // Synchronised levels
   pfms_src_t  src;                                           // All sources, clock domain

   assign async_src = {cmp0_i, fault1_i, fault0_pin_i};

   // Pins and comparator cross from outside the clock domain
   pfms_sync #(
      .W         (3)
   ) u_sync (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .async_i   (async_src),
      .sync_o    (sync_src)
   );

   // Debug level is already on this clock and needs no stages
   always_comb begin
      src     = '0;
      src.f0  = sync_src[0];
      src.f1  = sync_src[1];
      src.cmp = sync_src[2];
      src.dbg = debug_mode_i;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   logic       req;                                           // Live request not yet acked
   logic       wr_lane0;                                      // Write touching low byte
   logic       hit_mask;                                      // Address is fault_source_mask
   logic       hit_flag;                                      // Address is fault_event_flags
   logic [7:0] wr_byte;                                       // Low byte of write data

   assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_lane0 = req & wb_we_i & wb_sel_i[0];
   assign hit_mask = (wb_adr_i[31:2] == FSM_IDX);
   assign hit_flag = (wb_adr_i[31:2] == FEF_IDX);
   assign wr_byte  = wb_dat_i[7:0];

   ////////////////////////////////////////////////////////////////////////////
   // Mask register, locked after its first write

   logic [7:0] mask_ff;                                       // Stored mask
   logic       locked_ff;                                     // First write has happened
   logic [7:0] nxt_mask;
   logic       nxt_locked;

   // Only the first write lands; later ones are dropped without error
   always_comb begin
      nxt_mask   = mask_ff;
      nxt_locked = locked_ff;
      if (wr_lane0 && hit_mask && !locked_ff) begin
         // Reserved positions are never stored, so they read zero
         nxt_mask   = wr_byte & MSK_RW_BITS;
         nxt_locked = 1'b1;
      end
   end

   // Mask registers
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mask_ff   <= MSK_RESET;
         locked_ff <= 1'b0;
      end else begin
         mask_ff   <= nxt_mask;
         locked_ff <= nxt_locked;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Source enables and fault request

   pfms_src_t en;                                             // Source may raise a fault
   pfms_src_t act;                                            // Enabled and asserted

   always_comb begin
      en     = '0;
      en.dbg = ~mask_ff[MSK_DBG_BIT];
      en.f1  = ~mask_ff[MSK_F1_BIT];
      en.cmp = ~mask_ff[MSK_CMP_BIT];
      en.f0  = ~mask_ff[MSK_F0_BIT];
      act    = src & en;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky flags

   logic [SRC_N-1:0] src_set;                                 // Per source set
   logic [SRC_N-1:0] src_clr;                                 // Per source qualified clear
   logic [SRC_N-1:0] src_lvl;                                 // Per source raw level
   logic [SRC_N-1:0] src_flag;                                // Per source flag
   logic [SRC_N-1:0] clr_bit;                                 // Write-one per source
   logic             wr_flag;                                 // Write to flag register
   logic             rld_flag;                                // reload_seen_flag
   logic             rld_clr;                                 // Clear of reload flag

   assign wr_flag = wr_lane0 & hit_flag;

   // Gather per-source levels and clear bits in source order
   always_comb begin
      src_lvl          = '0;
      src_lvl[SRC_F0]  = src.f0;
      src_lvl[SRC_F1]  = src.f1;
      src_lvl[SRC_CMP] = src.cmp;
      src_lvl[SRC_DBG] = src.dbg;
      src_set          = '0;
      src_set[SRC_F0]  = act.f0;
      src_set[SRC_F1]  = act.f1;
      src_set[SRC_CMP] = act.cmp;
      src_set[SRC_DBG] = act.dbg;
      clr_bit          = '0;
      clr_bit[SRC_F0]  = wr_byte[FLG_F0_BIT];
      clr_bit[SRC_F1]  = wr_byte[FLG_F1_BIT];
      clr_bit[SRC_CMP] = wr_byte[FLG_CMP_BIT];
      clr_bit[SRC_DBG] = wr_byte[FLG_DBG_BIT];
   end

   // Clear only on a written one, and only once the source has gone
   assign src_clr = {SRC_N{wr_flag}} & clr_bit & ~src_lvl;

   // One flag cell per fault source
   for (genvar g = 0; g < SRC_N; g++) begin : g_flag
      pfms_flag u_flag (
         .sys_clk_i (sys_clk_i),
         .rstn_i    (rstn_i),
         .set_i     (src_set[g]),
         .clr_i     (src_clr[g]),
         .flag_o    (src_flag[g])
      );
   end

   // Reload flag has no source level to wait
   assign rld_clr = wr_flag & wr_byte[FLG_RLD_BIT];

   pfms_flag u_rld_flag (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .set_i     (reload_i),
      .clr_i     (rld_clr),
      .flag_o    (rld_flag)
   );

   logic [7:0] flags_view;                                    // Register image

   // Reserved status positions stay zero
   always_comb begin
      flags_view              = 8'h00;
      flags_view[FLG_F0_BIT]  = src_flag[SRC_F0];
      flags_view[FLG_F1_BIT]  = src_flag[SRC_F1];
      flags_view[FLG_CMP_BIT] = src_flag[SRC_CMP];
      flags_view[FLG_DBG_BIT] = src_flag[SRC_DBG];
      flags_view[FLG_RLD_BIT] = rld_flag;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus answer: ack one cycle after the strobe, dropped the next cycle

   logic        ack_ff;                                       // Acknowledge
   logic [31:0] rdat_ff;                                      // Read data
   logic        nxt_ack;
   logic [31:0] nxt_rdat;

   // Unmapped addresses are acked with zero data so a stray access never hangs
   always_comb begin
      nxt_ack  = req;
      nxt_rdat = rdat_ff;
      if (req && !wb_we_i) begin
         if (hit_mask) begin
            nxt_rdat = {24'h000000, mask_ff};
         end else if (hit_flag) begin
            nxt_rdat = {24'h000000, flags_view};
         end else begin
            nxt_rdat = 32'h00000000;
         end
      end
   end

   // Bus registers
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_ff  <= 1'b0;
         rdat_ff <= 32'h00000000;
      end else begin
         ack_ff  <= nxt_ack;
         rdat_ff <= nxt_rdat;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Fault outputs and recovery

   pfms_state_t state_ff;                                     // Output ownership
   pfms_state_t nxt_state;
   logic        fault_ff;                                     // Registered fault
   logic        exc_ff;                                       // Registered exception
   logic        nxt_fault;
   logic        nxt_exc;
   logic        any_act;                                      // Any enabled source active
   logic        any_flag;                                     // Any fault flag still set

   assign any_act  = |act;
   assign any_flag = |src_flag;

   // Software mode needs quiet sources, clean flags and a reload
   always_comb begin
      nxt_fault = any_act;
      nxt_exc   = act.cmp;
      nxt_state = state_ff;
      unique case (state_ff)
         PFMS_RUN: begin
            if (any_act) begin
               nxt_state = PFMS_HOLD;
            end
         end
         PFMS_HOLD: begin
            if (any_act) begin
               nxt_state = PFMS_HOLD;
            end else if (!sw_recovery_i) begin
               nxt_state = PFMS_RUN;
            end else if (!any_flag && reload_i) begin
               nxt_state = PFMS_RUN;
            end
         end
      endcase
   end

   // Fault registers
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_ff <= PFMS_RUN;
         fault_ff <= 1'b0;
         exc_ff   <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         fault_ff <= nxt_fault;
         exc_ff   <= nxt_exc;
      end
   end

   assign pwm_fault_o     = fault_ff;
   assign sys_fault_exc_o = exc_ff;
   assign outputs_off_o   = (state_ff == PFMS_HOLD);

endmodule : pfms_top
`default_nettype wire

// >>> sim/pfms_top_assertions.sv
// Checker for the PWM fault mask and status block, bound into pfms_top.
// Assumes it sees only the top ports; the locked mask is shadowed here.
`timescale 1ns/10ps
`default_nettype none
module pfms_chk
   import pfms_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        rstn_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [31:0] wb_dat_o,
   input  wire logic        wb_ack_o,
   input  wire logic        fault0_pin_i,
   input  wire logic        fault1_i,
   input  wire logic        cmp0_i,
   input  wire logic        debug_mode_i,
   input  wire logic        reload_i,
   input  wire logic        sw_recovery_i,
   input  wire logic        pwm_fault_o,
   input  wire logic        sys_fault_exc_o,
   input  wire logic        outputs_off_o
);
////////////////////////////////////////
   logic [7:0] mask_ff;                  // Shadow of the mask register
   logic [7:0] nxt_mask;
   logic       lock_ff;                  // Set once the first write landed
   logic       nxt_lock;
   logic       take;                     // Request taken at this edge
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // Only the first lane-0 write counts; later ones must not move the shadow
   always_comb begin
      nxt_mask = mask_ff;
      nxt_lock = lock_ff;
      if (take && wb_we_i && wb_sel_i[0] && wb_adr_i[31:2] == FSM_IDX && !lock_ff) begin
         nxt_mask = wb_dat_i[7:0] & MSK_RW_BITS;
         nxt_lock = 1'b1;
      end
   end
   // Shadow registers
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mask_ff <= MSK_RESET;
         lock_ff <= 1'b0;
      end else begin
         mask_ff <= nxt_mask;
         lock_ff <= nxt_lock;
      end
   end
////////////////////////////////////////
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   property p_ack_resp;
      take |=> wb_ack_o;
   endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("ack missing after request");
   property p_mask_read;
      wb_ack_o && !wb_we_i && wb_adr_i[31:2] == FSM_IDX |-> wb_dat_o == {24'h000000, mask_ff};
   endproperty
   a_mask_read: assert property (p_mask_read) else $error("mask readback wrong");
   property p_flag_rsvd;
      wb_ack_o && !wb_we_i && wb_adr_i[31:2] == FEF_IDX |-> wb_dat_o[31:8] == 24'h000000
         && wb_dat_o[6] == 1'b0 && wb_dat_o[4:3] == 2'h0;
   endproperty
   a_flag_rsvd: assert property (p_flag_rsvd) else $error("reserved flag bits not zero");
   property p_dbg_fault;
      debug_mode_i && !mask_ff[MSK_DBG_BIT] |=> pwm_fault_o;
   endproperty
   a_dbg_fault: assert property (p_dbg_fault) else $error("debug entry gave no fault");
   // Three cycles of a fully locked mask cover the pipeline from sync to output
   property p_masked_quiet;
      mask_ff == MSK_RW_BITS && $past(mask_ff, 3) == MSK_RW_BITS |-> !pwm_fault_o && !sys_fault_exc_o;
   endproperty
   a_masked_quiet: assert property (p_masked_quiet) else $error("masked source faulted");
   property p_cmp_exc;
      cmp0_i [*4] ##0 !mask_ff[MSK_CMP_BIT] |-> sys_fault_exc_o && pwm_fault_o;
   endproperty
   a_cmp_exc: assert property (p_cmp_exc) else $error("comparator fault or exception missing");
   property p_off_follow;
      pwm_fault_o |-> outputs_off_o;
   endproperty
   a_off_follow: assert property (p_off_follow) else $error("outputs not off during fault");
   property p_sw_hold;
      sw_recovery_i && outputs_off_o && !reload_i |=> outputs_off_o;
   endproperty
   a_sw_hold: assert property (p_sw_hold) else $error("released without reload");
   c_lock: cover property ($rose(lock_ff));
   c_exc: cover property ($rose(sys_fault_exc_o));
   c_sw_rel: cover property (sw_recovery_i && $fell(outputs_off_o));
endmodule : pfms_chk

bind pfms_top pfms_chk u_chk (
   .sys_clk_i, .rstn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
   .wb_dat_o, .wb_ack_o, .fault0_pin_i, .fault1_i, .cmp0_i, .debug_mode_i, .reload_i,
   .sw_recovery_i, .pwm_fault_o, .sys_fault_exc_o, .outputs_off_o
);
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the PWM fault mask and status block.
// Assumes pfms_top alone; the checker is attached by bind.
`timescale 1ns/10ps
`default_nettype none
module testbench
   import pfms_pkg::*;
;
   localparam logic [31:0] A_MSK = {FSM_IDX, 2'h0};  // Mask register
   localparam logic [31:0] A_FLG = {FEF_IDX, 2'h0};  // Flag register
   localparam logic [31:0] A_BAD = 32'h00000100;      // Unmapped word
   logic        sys_clk_i     = 1'b0;
   logic        rstn_i        = 1'b0;
   logic        wb_cyc_i      = 1'b0;
   logic        wb_stb_i      = 1'b0;
   logic        wb_we_i       = 1'b0;
   logic [31:0] wb_adr_i      = 32'h0;
   logic [3:0]  wb_sel_i      = 4'hF;                 // Always full word
   logic [31:0] wb_dat_i      = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   pfms_src_t   src           = '0;                   // Fault source levels
   logic        reload_i      = 1'b0;
   logic        sw_recovery_i = 1'b0;
   logic        pwm_fault_o;
   logic        sys_fault_exc_o;
   logic        outputs_off_o;
   int          error_cnt     = 0;
   int          tests_run     = 0;
   always #4 sys_clk_i = ~sys_clk_i;
   pfms_top u_dut (
      .sys_clk_i, .rstn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .fault0_pin_i(src.f0), .fault1_i(src.f1), .cmp0_i(src.cmp),
      .debug_mode_i(src.dbg), .reload_i, .sw_recovery_i, .pwm_fault_o, .sys_fault_exc_o,
      .outputs_off_o
   );
////////////////////////////////////////
   // Compare and report
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // One classic cycle; values read here are those sampled at the edge
   task automatic wb_cycle(input logic we, input logic [31:0] adr, input logic [31:0] dat,
                           output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      chk("ack", 32'h1, {31'h0, wb_ack_o});
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask : wb_cycle
   task automatic wr(input logic [31:0] adr, input logic [31:0] dat);
      logic [31:0] rd;
      wb_cycle(1'b1, adr, dat, rd);
   endtask : wr
   task automatic rd_chk(input string nm, input logic [31:0] adr, input logic [31:0] exp);
      logic [31:0] rd;
      wb_cycle(1'b0, adr, 32'h0, rd);
      chk(nm, exp, rd);
   endtask : rd_chk
   // Two edges: reload seen at the first, result visible at the second
   task automatic pulse_reload();
      reload_i <= 1'b1;
      @(posedge sys_clk_i);
      reload_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask : pulse_reload
   task automatic chk_outs(input logic flt, input logic exc, input logic off);
      chk("pwm_fault", {31'h0, flt}, {31'h0, pwm_fault_o});
      chk("sys_exc", {31'h0, exc}, {31'h0, sys_fault_exc_o});
      chk("outputs_off", {31'h0, off}, {31'h0, outputs_off_o});
   endtask : chk_outs
////////////////////////////////////////
   task automatic t_reset();
      rd_chk("mask_reset", A_MSK, 32'h0);
      rd_chk("flags_reset", A_FLG, 32'h0);
      wr(A_FLG, 32'hFF);
      wr(A_BAD, 32'hFF);
      rd_chk("unmapped", A_BAD, 32'h0);
   endtask : t_reset
   // Each source alone: fault, flag, blocked clear, auto release, clears
   task automatic t_sources();
      int fb [4] = '{0, 1, 2, 5};
      for (int i = 0; i < SRC_N; i++) begin
         src <= pfms_src_t'(4'h1 << i);
         repeat (4) @(posedge sys_clk_i);
         chk_outs(1'b1, i == SRC_CMP, 1'b1);
         rd_chk("flag_set", A_FLG, 32'h1 << fb[i]);
         wr(A_FLG, 32'h1 << fb[i]);
         rd_chk("flag_held", A_FLG, 32'h1 << fb[i]);
         src <= '0;
         repeat (5) @(posedge sys_clk_i);
         chk_outs(1'b0, 1'b0, 1'b0);
         wr(A_FLG, 32'h0);
         rd_chk("flag_w0", A_FLG, 32'h1 << fb[i]);
         wr(A_FLG, 32'hFF);
         rd_chk("flag_clr", A_FLG, 32'h0);
      end
   endtask : t_sources
   task automatic t_reload();
      pulse_reload();
      rd_chk("reload_flag", A_FLG, 32'h80);
      wr(A_FLG, 32'h80);
      rd_chk("reload_clr", A_FLG, 32'h0);
   endtask : t_reload
   // Software recovery: a reload with a flag still set must not release
   task automatic t_sw_recovery();
      sw_recovery_i <= 1'b1;
      src <= pfms_src_t'(4'h1);
      repeat (4) @(posedge sys_clk_i);
      src <= '0;
      repeat (4) @(posedge sys_clk_i);
      pulse_reload();
      chk("hold_flag", 32'h1, {31'h0, outputs_off_o});
      wr(A_FLG, 32'hFF);
      chk("hold_noreload", 32'h1, {31'h0, outputs_off_o});
      pulse_reload();
      chk("sw_release", 32'h0, {31'h0, outputs_off_o});
      rd_chk("sw_flags", A_FLG, 32'h80);
      wr(A_FLG, 32'hFF);
      sw_recovery_i <= 1'b0;
   endtask : t_sw_recovery
   // Lock every mask, then all sources together stay silent
   task automatic t_mask();
      wr(A_MSK, 32'h27);
      rd_chk("mask_first", A_MSK, 32'h27);
      wr(A_MSK, 32'h00);
      rd_chk("mask_locked", A_MSK, 32'h27);
      src <= pfms_src_t'(4'hF);
      repeat (4) @(posedge sys_clk_i);
      chk_outs(1'b0, 1'b0, 1'b0);
      rd_chk("flags_masked", A_FLG, 32'h0);
      src <= '0;
   endtask : t_mask
   // A mid-run reset unlocks the mask; then only the comparator is masked
   task automatic t_partial();
      rstn_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      rd_chk("mask_rst2", A_MSK, 32'h0);
      wr(A_MSK, 32'h02);
      rd_chk("mask_cmp", A_MSK, 32'h2);
      src <= pfms_src_t'(4'h5);
      repeat (4) @(posedge sys_clk_i);
      chk_outs(1'b1, 1'b0, 1'b1);
      rd_chk("flags_cmp_masked", A_FLG, 32'h1);
      src <= '0;
      repeat (4) @(posedge sys_clk_i);
      chk_outs(1'b0, 1'b0, 1'b0);
      wr(A_FLG, 32'hFF);
      rd_chk("flags_clr2", A_FLG, 32'h0);
   endtask : t_partial
   task automatic finish_test();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test
////////////////////////////////////////
   // Main sequence; the mask tests go last because only a reset undoes the lock
   initial begin
      repeat (5) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      t_reset();
      t_sources();
      t_reload();
      t_sw_recovery();
      t_mask();
      t_partial();
      finish_test();
   end
   // Watchdog, far beyond the few hundred cycles the run needs
   initial begin
      #100000;
      error_cnt++;
      finish_test();
   end
endmodule : testbench
`default_nettype wire
